// ---- verilog/debug_gate_pkg.sv ----
// constants, types and state layout of the debug unlock and command gate
package debug_gate_pkg;

  localparam int CLK_PERIOD_NS      = 50;
  localparam int UNLOCK_WAIT_NS     = 5_000_000;
  localparam int UNLOCK_WAIT_CYCLES = (UNLOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int BAUD_W = 10;
  localparam int MEAS_W = 13;
  localparam int WAIT_W = 17;
  localparam int DATA_W = 17;

  localparam int CMD_FIFO_DEPTH = 4;

  localparam logic [MEAS_W-1:0] MEAS_MAX       = 13'h1fff;
  localparam int                AUTOBAUD_SHIFT = 3;
  localparam logic [BAUD_W-1:0] BAUD_MIN       = 10'h004;
  localparam logic [BAUD_W-1:0] BAUD_MAX       = 10'h200;
  localparam logic [MEAS_W-1:0] BREAK_LOW_BITS = 13'h0009;
  localparam logic [5:0]        BREAK_TX_LAST  = 6'h27;
  localparam logic [5:0]        FRAME_STOP     = 6'h09;
  localparam logic [2:0]        SYNC_IDLE      = 3'h7;

  localparam logic [31:0] UNLOCK_KEY  = 32'heb5a70cd;
  localparam logic [2:0]  KEY_DONE    = 3'h4;

  localparam logic [7:0] CMD_READ_REV     = 8'h00;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h02;
  localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_WRITE_CTL    = 8'h04;
  localparam logic [7:0] CMD_READ_CTL     = 8'h05;
  localparam logic [7:0] CMD_WRITE_PC     = 8'h06;
  localparam logic [7:0] CMD_READ_PC      = 8'h07;
  localparam logic [7:0] CMD_WRITE_REG    = 8'h08;
  localparam logic [7:0] CMD_READ_REG     = 8'h09;
  localparam logic [7:0] CMD_WRITE_PMEM   = 8'h0a;
  localparam logic [7:0] CMD_READ_PMEM    = 8'h0b;
  localparam logic [7:0] CMD_WRITE_DMEM   = 8'h0c;
  localparam logic [7:0] CMD_READ_DMEM    = 8'h0d;
  localparam logic [7:0] CMD_READ_CRC     = 8'h0e;
  localparam logic [7:0] CMD_STEP         = 8'h10;
  localparam logic [7:0] CMD_STUFF        = 8'h11;
  localparam logic [7:0] CMD_EXECUTE      = 8'h12;

  localparam logic [DATA_W-1:0] REG_SIZE_ZERO = 17'h00100;
  localparam logic [DATA_W-1:0] MEM_SIZE_ZERO = 17'h10000;

  localparam int CTL_DEBUG_MODE_BIT = 7;
  localparam int CTL_BRK_ENABLE_BIT = 5;
  localparam int STAT_DEBUG_BIT     = 7;
  localparam int STAT_PROTECT_BIT   = 6;

  // arbitrary value; bump whenever the command set changes
  localparam logic [15:0] DEBUG_REVISION = 16'h0101;
  localparam logic [15:0] NO_DATA        = 16'hffff;
  localparam logic [15:0] RUN_MAX        = 16'hffff;

  localparam logic [11:0] FLASH_CTL_LO   = 12'hff8;
  localparam logic [11:0] FLASH_CMD_REG  = 12'hff8;
  localparam logic [7:0]  MASS_ERASE_VAL = 8'h63;

  typedef enum logic [2:0] {
    ST_BAUD_WAIT = 3'b000,
    ST_BAUD_MEAS = 3'b001,
    ST_IDLE      = 3'b011,
    ST_RX        = 3'b010,
    ST_TX        = 3'b111,
    ST_BREAK     = 3'b110,
    ST_RELEASE   = 3'b100
  } link_t;

  typedef struct packed {
    logic       first;
    logic       allowed;
    logic [7:0] data;
  } cmd_word_t;

  localparam int CMD_WORD_W = $bits(cmd_word_t);

  typedef struct packed {
    logic [2:0]        line_s;
    logic [2:0]        rst_s;
    logic              line_q;
    logic              rst_low_q;
    link_t             link;
    logic [BAUD_W-1:0] baud_q;
    logic [MEAS_W-1:0] tmr_q;
    logic [MEAS_W-1:0] low_q;
    logic [5:0]        bit_q;
    logic [7:0]        sh_q;
    logic              tx_oe_n_q;
    logic              pin_out_q;
    logic [15:0]       resp_q;
    logic [1:0]        resp_n_q;
    logic [WAIT_W-1:0] wait_q;
    logic [2:0]        key_q;
    logic              key_bad_q;
    logic              unlocked_q;
    logic              gpio_q;
    logic [7:0]        ctl_q;
    logic [7:0]        cmd_q;
    logic              cmd_ok_q;
    logic [2:0]        arg_q;
    logic [DATA_W-1:0] data_q;
    logic [11:0]       addr_q;
    logic              pend_q;
    cmd_word_t         pend_w;
    logic [15:0]       run_q;
    logic              brk_nop_q;
    logic              err_q;
  } gate_state_t;

endpackage

// ---- verilog/cmd_fifo.sv ----
// shift-register fifo whose head entry is the registered read data
`timescale 1ns/10ps
module cmd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               cnt;
    logic                        valid;
    logic                        ready;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;

  always_comb begin
    d = q;
    if (q.valid && i_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.mem[i] = q.mem[i+1];
      end
      d.cnt = d.cnt - CW'(1);
    end
    if (i_valid && q.ready) begin
      d.mem[d.cnt] = i_data;
      d.cnt = d.cnt + CW'(1);
    end
    d.valid = d.cnt != '0;
    // ready only from the stored count, so full is honest
    d.ready = d.cnt != CW'(DEPTH);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q       <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_ready = q.ready;
  assign o_valid = q.valid;
  assign o_data  = q.mem[0];

endmodule

// ---- verilog/debug_unlock_command_gate.sv ----
// unlock, autobaud serial link, breakpoint, runtime counter and command gate
`timescale 1ns/10ps
// What this block does
// - small package without a completed unlock keeps the shared pin as plain gpio
// - correct key plus reset pin release makes shared pin a full debug line
// - breakpoint opcode with breakpoints enabled enters debug mode and idles cpu
// - breakpoint opcode with breakpoints disabled is ignored and runs as no-op
// - 16-bit runtime counter runs outside debug mode, stops at FFFFH
// - outside debug mode only commands 00H 02H 04H 05H execute
// - in debug mode all defined commands run unless read protect is set
// - 00H read revision, 02H read status, 03H read runtime counter
// - 04H writes control register, 05H reads control register
// - 06H to 0EH memory, register and pc commands; 10H to 12H step stuff execute
// - read protect disables pc, register read, program memory, data write, step group
// - read protect limits register writes to flash control and mass erase value
// - read protect makes control writes unable to clear the debug mode bit
// - revision value changes whenever the command set changes
// - each character is start bit, eight data bits lsb first, stop bit
// - first character 80H low period sets the bit rate
// - more than nine low bit times is a break and resets bit rate
// - break, framing error or collision aborts, sends 4-char break, reautobauds
module debug_unlock_command_gate
  import debug_gate_pkg::*;
#(
  parameter int UNLOCK_WAIT = UNLOCK_WAIT_CYCLES
) (
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  // debug line pin, open drain
  input  wire logic      i_debug_line,
  output logic           o_debug_line_out,
  output logic           o_debug_line_oe_n,
  // package strap and shared reset pin
  input  wire logic      i_small_package,
  input  wire logic      i_shared_reset_pin,
  // cpu and option bits
  input  wire logic      i_read_protect_option,
  input  wire logic      i_breakpoint_opcode,
  // status towards the core
  output logic           o_gpio_mode,
  output logic           o_debug_mode,
  output logic           o_breakpoint_nop,
  output logic [15:0]    o_runtime_count,
  output logic [7:0]     o_control,
  output logic           o_link_error,
  // gated command stream
  output logic           o_cmd_valid,
  output cmd_word_t      o_cmd_word,
  input  wire logic      i_cmd_ready
);

  gate_state_t q;
  gate_state_t d;
  logic        fifo_ready;

  function automatic logic cmd_reserved(input logic [7:0] c);
    return (c > CMD_EXECUTE) || (c == CMD_READ_REV + 8'h01) || (c == CMD_READ_CRC + 8'h01);
  endfunction

  function automatic logic cmd_gate(input logic [7:0] c, input logic dbg, input logic rp);
    logic ok;
    ok = 1'b1;
    if (!dbg) begin
      ok = (c == CMD_READ_REV) || (c == CMD_READ_STATUS) ||
           (c == CMD_WRITE_CTL) || (c == CMD_READ_CTL);
    end else if (rp) begin
      ok = !((c == CMD_WRITE_PC) || (c == CMD_READ_PC) || (c == CMD_READ_REG) ||
             (c == CMD_WRITE_PMEM) || (c == CMD_READ_PMEM) || (c == CMD_WRITE_DMEM) ||
             (c == CMD_STEP) || (c == CMD_STUFF) || (c == CMD_EXECUTE));
    end
    return ok;
  endfunction

  function automatic logic [2:0] arg_count(input logic [7:0] c);
    logic [2:0] n;
    n = 3'h0;
    case (c)
      CMD_WRITE_CTL, CMD_STUFF, CMD_EXECUTE:                       n = 3'h1;
      CMD_WRITE_PC:                                                n = 3'h2;
      CMD_WRITE_REG, CMD_READ_REG:                                 n = 3'h3;
      CMD_WRITE_PMEM, CMD_READ_PMEM, CMD_WRITE_DMEM, CMD_READ_DMEM: n = 3'h4;
      default:                                                     n = 3'h0;
    endcase
    return n;
  endfunction

  always_comb begin
    logic                err;
    logic                byte_v;
    logic                wait_done;
    logic                key_mode;
    logic                listen;
    logic                line;
    logic                release_pin;
    logic                ok;
    logic [MEAS_W-1:0]   bit_len;
    logic [MEAS_W-1:0]   half;
    logic [MEAS_W-1:0]   brk_limit;
    logic [BAUD_W-1:0]   baud_new;
    logic [9:0]          frame;
    logic [5:0]          next_bit;
    logic [7:0]          b;
    logic [7:0]          status;
    logic [15:0]         size;
    err         = 1'b0;
    byte_v      = 1'b0;
    ok          = 1'b0;
    b           = q.sh_q;
    status      = '0;
    size        = '0;
    d           = q;
    d.err_q     = 1'b0;
    d.brk_nop_q = 1'b0;
    d.pin_out_q = 1'b0;

    // three stage pin synchronisers, change taken once stages two and three agree
    d.line_s = {q.line_s[1:0], i_debug_line};
    d.rst_s  = {q.rst_s[1:0], i_shared_reset_pin};
    if (q.line_s[1] == q.line_s[2]) begin
      d.line_q = q.line_s[2];
    end
    if (q.rst_s[1] == q.rst_s[2]) begin
      d.rst_low_q = ~q.rst_s[2];
    end
    release_pin = q.rst_low_q && (q.rst_s[1] == q.rst_s[2]) && q.rst_s[2];

    // key bytes only count once the internal reset has settled
    wait_done = q.wait_q == WAIT_W'(UNLOCK_WAIT);
    if (!q.rst_low_q) begin
      d.wait_q = '0;
    end else if (!wait_done) begin
      d.wait_q = q.wait_q + WAIT_W'(1);
    end
    key_mode = i_small_package && q.rst_low_q;
    listen   = !i_small_package || q.unlocked_q || (q.rst_low_q && wait_done);
    line     = listen ? q.line_q : 1'b1;
    d.gpio_q = i_small_package && !q.unlocked_q;

    bit_len   = {3'h0, q.baud_q};
    half      = {4'h0, q.baud_q[BAUD_W-1:1]};
    brk_limit = bit_len * BREAK_LOW_BITS;
    if (line) begin
      d.low_q = '0;
    end else if (q.low_q != MEAS_MAX) begin
      d.low_q = q.low_q + MEAS_W'(1);
    end

    next_bit = q.bit_q + 6'h01;
    frame    = {1'b1, q.resp_q[15:8], 1'b0};
    baud_new = q.tmr_q[MEAS_W-1:AUTOBAUD_SHIFT];

    unique case (q.link)
      ST_BAUD_WAIT: begin
        d.tmr_q = '0;
        if (!line) begin
          d.link = ST_BAUD_MEAS;
          d.tmr_q = MEAS_W'(1); // the first low cycle counts too
        end
      end
      ST_BAUD_MEAS: begin
        // eight low bit times of 80H give the bit length
        if (line) begin
          if (baud_new >= BAUD_MIN && baud_new <= BAUD_MAX) begin
            d.baud_q = baud_new;
            d.link   = ST_IDLE;
          end else begin
            d.link = ST_BAUD_WAIT;
          end
        end else if (q.tmr_q == MEAS_MAX) begin
          d.link = ST_RELEASE;
        end else begin
          d.tmr_q = q.tmr_q + MEAS_W'(1);
        end
      end
      ST_IDLE: begin
        if (!line) begin
          d.link  = ST_RX;
          d.tmr_q = half;
          d.bit_q = '0;
        end else if (q.resp_n_q != 2'h0) begin
          d.link      = ST_TX;
          d.tmr_q     = bit_len - MEAS_W'(1);
          d.bit_q     = '0;
          d.tx_oe_n_q = 1'b0;
        end
      end
      ST_RX: begin
        if (q.tmr_q != '0) begin
          d.tmr_q = q.tmr_q - MEAS_W'(1);
        end else begin
          d.tmr_q = bit_len - MEAS_W'(1);
          d.bit_q = next_bit;
          if (q.bit_q == '0) begin
            if (line) begin
              d.link = ST_IDLE;
            end
          end else if (q.bit_q < FRAME_STOP) begin
            d.sh_q = {line, q.sh_q[7:1]};
          end else if (!line) begin
            err = 1'b1;
          end else begin
            byte_v = 1'b1;
            d.link = ST_IDLE;
          end
        end
      end
      ST_TX: begin
        // released bit low at its end is a collision; sync lags too far at mid-bit
        if (q.tmr_q == '0 && q.tx_oe_n_q && !line) begin
          err = 1'b1;
        end
        if (q.tmr_q != '0) begin
          d.tmr_q = q.tmr_q - MEAS_W'(1);
        end else if (q.bit_q == FRAME_STOP) begin
          d.link      = ST_IDLE;
          d.tx_oe_n_q = 1'b1;
          d.resp_q    = {q.resp_q[7:0], 8'h00};
          d.resp_n_q  = q.resp_n_q - 2'h1;
        end else begin
          d.tmr_q     = bit_len - MEAS_W'(1);
          d.bit_q     = next_bit;
          d.tx_oe_n_q = frame[next_bit[3:0]];
        end
      end
      ST_BREAK: begin
        d.tx_oe_n_q = 1'b0;
        if (q.tmr_q != '0) begin
          d.tmr_q = q.tmr_q - MEAS_W'(1);
        end else if (q.bit_q == BREAK_TX_LAST) begin
          d.link      = ST_RELEASE;
          d.tx_oe_n_q = 1'b1;
        end else begin
          d.tmr_q = bit_len - MEAS_W'(1);
          d.bit_q = next_bit;
        end
      end
      ST_RELEASE: begin
        // held here until the host lets its own break go
        d.tx_oe_n_q = 1'b1;
        if (line) begin
          d.link = ST_BAUD_WAIT;
        end
      end
      default: begin
        d.link = ST_RELEASE;
      end
    endcase

    // a 00H frame alone is nine bit times low
    if ((q.link == ST_IDLE || q.link == ST_RX || q.link == ST_TX) && q.low_q > brk_limit) begin
      err = 1'b1;
    end

    if (q.pend_q && fifo_ready) begin
      d.pend_q = 1'b0;
    end

    if (byte_v && key_mode) begin
      if (q.key_q != KEY_DONE && b == UNLOCK_KEY[{q.key_q[1:0] ^ 2'h3, 3'h0} +: 8]) begin
        d.key_q = q.key_q + 3'h1;
      end else begin
        d.key_bad_q = 1'b1;
      end
    end else if (byte_v && d.pend_q) begin
      err = 1'b1; // fifo stalled past one held byte
    end else if (byte_v && q.arg_q != '0) begin
      d.arg_q  = q.arg_q - 3'h1;
      d.pend_q = 1'b1;
      d.pend_w = '{first: 1'b0, allowed: q.cmd_ok_q, data: b};
      if (q.cmd_q == CMD_WRITE_CTL && q.cmd_ok_q) begin
        d.ctl_q = b;
        if (i_read_protect_option && q.ctl_q[CTL_DEBUG_MODE_BIT]) begin
          d.ctl_q[CTL_DEBUG_MODE_BIT] = 1'b1;
        end
      end else if (q.cmd_q == CMD_WRITE_REG) begin
        if (q.arg_q == 3'h3) begin
          d.addr_q[11:8] = b[3:0];
        end else if (q.arg_q == 3'h2) begin
          d.addr_q[7:0] = b;
        end else begin
          d.data_q = (b == 8'h00) ? REG_SIZE_ZERO : {9'h000, b};
        end
      end else if (q.cmd_q == CMD_WRITE_PMEM || q.cmd_q == CMD_WRITE_DMEM) begin
        if (q.arg_q == 3'h2) begin
          d.data_q = {1'b0, b, 8'h00};
        end else if (q.arg_q == 3'h1) begin
          size     = {q.data_q[15:8], b};
          d.data_q = (size == 16'h0000) ? MEM_SIZE_ZERO : {1'b0, size};
        end
      end
    end else if (byte_v && q.data_q != '0) begin
      d.data_q = q.data_q - DATA_W'(1);
      ok       = q.cmd_ok_q;
      if (q.cmd_q == CMD_WRITE_REG) begin
        d.addr_q = q.addr_q + 12'h001;
        if (i_read_protect_option) begin
          ok = ok && q.addr_q >= FLASH_CTL_LO &&
               (q.addr_q != FLASH_CMD_REG || b == MASS_ERASE_VAL);
        end
      end
      d.pend_q = 1'b1;
      d.pend_w = '{first: 1'b0, allowed: ok, data: b};
    end else if (byte_v && !cmd_reserved(b)) begin
      ok         = cmd_gate(b, q.ctl_q[CTL_DEBUG_MODE_BIT], i_read_protect_option);
      d.cmd_q    = b;
      d.cmd_ok_q = ok;
      d.arg_q    = arg_count(b);
      d.pend_q   = 1'b1;
      d.pend_w   = '{first: 1'b1, allowed: ok, data: b};
      status[STAT_DEBUG_BIT]   = q.ctl_q[CTL_DEBUG_MODE_BIT];
      status[STAT_PROTECT_BIT] = i_read_protect_option;
      if (ok && b == CMD_READ_REV) begin
        d.resp_q   = DEBUG_REVISION;
        d.resp_n_q = 2'h2;
      end else if (ok && b == CMD_READ_STATUS) begin
        d.resp_q   = {status, 8'h00};
        d.resp_n_q = 2'h1;
      end else if (ok && b == CMD_READ_RUNTIME) begin
        d.resp_q   = q.run_q;
        d.resp_n_q = 2'h2;
      end else if (ok && b == CMD_READ_CTL) begin
        d.resp_q   = {q.ctl_q, 8'h00};
        d.resp_n_q = 2'h1;
      end else if (!ok && b == CMD_READ_PC) begin
        d.resp_q   = NO_DATA;
        d.resp_n_q = 2'h2;
      end
    end

    if (err) begin
      d.link      = ST_BREAK;
      d.tmr_q     = bit_len - MEAS_W'(1);
      d.bit_q     = '0;
      d.tx_oe_n_q = 1'b0;
      d.arg_q     = '0;
      d.data_q    = '0;
      d.pend_q    = 1'b0;
      d.resp_n_q  = 2'h0;
      d.err_q     = 1'b1;
    end

    if (i_small_package && release_pin) begin
      d.unlocked_q = q.unlocked_q || (q.key_q == KEY_DONE && !q.key_bad_q);
      d.key_q      = '0;
      d.key_bad_q  = 1'b0;
      d.link       = ST_BAUD_WAIT;
      d.tx_oe_n_q  = 1'b1;
    end

    // breakpoint set wins over a clearing control write in the same cycle
    if (i_breakpoint_opcode) begin
      if (q.ctl_q[CTL_BRK_ENABLE_BIT]) begin
        d.ctl_q[CTL_DEBUG_MODE_BIT] = 1'b1;
      end else begin
        d.brk_nop_q = 1'b1;
      end
    end

    if (q.ctl_q[CTL_DEBUG_MODE_BIT] && !d.ctl_q[CTL_DEBUG_MODE_BIT]) begin
      d.run_q = '0;
    end else if (!q.ctl_q[CTL_DEBUG_MODE_BIT] && q.run_q != RUN_MAX) begin
      d.run_q = q.run_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q           <= '0;
      q.line_s    <= SYNC_IDLE;
      q.rst_s     <= SYNC_IDLE;
      q.line_q    <= 1'b1;
      q.link      <= ST_BAUD_WAIT;
      q.tx_oe_n_q <= 1'b1;
      q.gpio_q    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  cmd_fifo #(
    .WIDTH (CMD_WORD_W),
    .DEPTH (CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (q.pend_q),
    .o_ready (fifo_ready),
    .i_data  (q.pend_w),
    .o_valid (o_cmd_valid),
    .i_ready (i_cmd_ready),
    .o_data  (o_cmd_word)
  );

  assign o_debug_line_out  = q.pin_out_q;
  assign o_debug_line_oe_n = q.tx_oe_n_q;
  assign o_gpio_mode       = q.gpio_q;
  assign o_debug_mode      = q.ctl_q[CTL_DEBUG_MODE_BIT];
  assign o_breakpoint_nop  = q.brk_nop_q;
  assign o_runtime_count   = q.run_q;
  assign o_control         = q.ctl_q;
  assign o_link_error      = q.err_q;

endmodule

// ---- sim/host_link.sv ----
// host side of the open-drain debug line: bit-banged sender and idle watcher
`timescale 1ns/10ps
module host_link #(
  parameter int BIT = 8
) (
  // clock and line level
  input  wire logic i_clk,
  input  wire logic i_line,
  // host pull-down, low pulls the line low
  output logic      o_oe_n
);
  initial o_oe_n = 1'b1;
  logic       seen_q = 1'b1;
  logic [7:0] rx[$];
  logic [7:0] rb;
  // replies: line low after the host was released a cycle
  always @(negedge i_clk) begin
    if (seen_q && o_oe_n && !i_line) begin
      repeat (BIT + BIT / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
        rb[i] = i_line;
        repeat (BIT) @(negedge i_clk);
      end
      rx.push_back(rb);
    end
    seen_q = o_oe_n;
  end
  // start low, data lsb first, stop released
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_oe_n = f[i];
      repeat (BIT) @(negedge i_clk);
    end
  endtask
  // held low well past nine bit times
  task automatic hold_low(input int n);
    o_oe_n = 1'b0;
    repeat (n * BIT) @(negedge i_clk);
    o_oe_n = 1'b1;
  endtask
  // half duplex: let any reply finish before the next byte
  task automatic quiet(output bit ok);
    int run;
    run = 0;
    ok = 1'b0;
    for (int n = 0; n < 4000 && !ok; n++) begin
      @(negedge i_clk);
      run = i_line ? run + 1 : 0;
      ok = run > 12 * BIT;
    end
  endtask
endmodule

// ---- sim/debug_gate_checker_props.sv ----
// checker of gating, breakpoint and runtime behaviour at the gate ports
`timescale 1ns/10ps
module debug_gate_checker
  import debug_gate_pkg::*;
#(
  parameter int UNLOCK_WAIT = 20
) (
  // gate inputs
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_small_package,
  input wire logic        i_shared_reset_pin,
  input wire logic        i_read_protect_option,
  input wire logic        i_breakpoint_opcode,
  // gate outputs
  input wire logic        o_gpio_mode,
  input wire logic        o_debug_mode,
  input wire logic        o_breakpoint_nop,
  input wire logic [15:0] o_runtime_count,
  input wire logic [7:0]  o_control,
  input wire logic        o_cmd_valid,
  input wire cmd_word_t   o_cmd_word
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_GPIO_HOLD: assert property (i_small_package && $fell(o_gpio_mode) |-> i_shared_reset_pin)
    else $error("shared pin left gpio while reset pin low");
  AST_BRK_ENTER: assert property (i_breakpoint_opcode && o_control[5] |=> o_debug_mode)
    else $error("enabled breakpoint did not enter debug mode");
  AST_BRK_NOP: assert property (i_breakpoint_opcode && !o_control[5] |=> o_breakpoint_nop)
    else $error("disabled breakpoint gave no nop pulse");
  AST_NOP_CAUSE: assert property (o_breakpoint_nop |-> $past(i_breakpoint_opcode) && !$past(o_control[5]))
    else $error("nop pulse without disabled breakpoint");
  AST_RUN_INC: assert property (!o_debug_mode && !$past(o_debug_mode) && o_runtime_count != RUN_MAX
    |=> o_debug_mode || o_runtime_count == $past(o_runtime_count) + 16'h1)
    else $error("runtime counter did not advance");
  AST_RUN_HOLD: assert property (o_debug_mode && $past(o_debug_mode) |-> $stable(o_runtime_count))
    else $error("runtime counter moved in debug mode");
  AST_GATE: assert property (o_cmd_valid && o_cmd_word.first && o_cmd_word.allowed && !o_debug_mode
    |-> o_cmd_word.data inside {8'h00, 8'h02, 8'h04, 8'h05})
    else $error("command allowed outside debug mode");
  AST_RSVD: assert property (o_cmd_valid && o_cmd_word.first
    |-> !(o_cmd_word.data inside {8'h01, 8'h0f}) && o_cmd_word.data < 8'h13)
    else $error("reserved code reached the command stream");
  AST_PROT: assert property (o_cmd_valid && o_cmd_word.first && i_read_protect_option |-> !(o_cmd_word.allowed
    && o_cmd_word.data inside {8'h06, 8'h07, 8'h09, [8'h0a:8'h0c], [8'h10:8'h12]}))
    else $error("protected command allowed");
  AST_PROT_DBG: assert property (i_read_protect_option && o_debug_mode |=> o_debug_mode)
    else $error("debug mode cleared under read protect");
endmodule
bind debug_unlock_command_gate debug_gate_checker #(.UNLOCK_WAIT(UNLOCK_WAIT)) i_debug_gate_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_small_package(i_small_package),
  .i_shared_reset_pin(i_shared_reset_pin), .i_read_protect_option(i_read_protect_option),
  .i_breakpoint_opcode(i_breakpoint_opcode), .o_gpio_mode(o_gpio_mode),
  .o_debug_mode(o_debug_mode), .o_breakpoint_nop(o_breakpoint_nop),
  .o_runtime_count(o_runtime_count), .o_control(o_control), .o_cmd_valid(o_cmd_valid),
  .o_cmd_word(o_cmd_word)
);

// ---- sim/debug_unlock_command_gate_tb_top.sv ----
// self-checking bench: unlock, command gating, breakpoints, runtime, break
`timescale 1ns/10ps
module debug_unlock_command_gate_tb_top
  import debug_gate_pkg::*;
;
  localparam int UW = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rpin = 1'b0;
  logic        prot = 1'b0;
  logic        breakpoint_opcode = 1'b0;
  logic        rdy = 1'b0;
  logic        hold = 1'b0;
  logic        sp = 1'b1;
  logic        host_oe_n, oe_n, line, gpio, dbg, nop, lerr, cvalid;
  logic [15:0] run;
  logic [7:0]  ctl;
  cmd_word_t   cword;
  cmd_word_t   exp_q[$];
  logic [7:0]  m_ctl = 8'h00;
  logic [31:0] seed = 32'h5a59;
  logic [7:0]  cl[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h0e, 8'h0f, 8'h10, 8'h13, 8'hff};
  int          err_count = 0;
  int          compares = 0;
  int          n_err = 0;
  logic [15:0] r;

  always #25 clk = ~clk;
  // open drain with pull-up: low if either side pulls
  assign line = oe_n & host_oe_n;

  debug_unlock_command_gate #(.UNLOCK_WAIT(UW)) i_debug_unlock_command_gate (
    .i_clk(clk), .i_rst_n(rst_n), .i_debug_line(line), .o_debug_line_out(),
    .o_debug_line_oe_n(oe_n), .i_small_package(sp), .i_shared_reset_pin(rpin),
    .i_read_protect_option(prot), .i_breakpoint_opcode(breakpoint_opcode), .o_gpio_mode(gpio),
    .o_debug_mode(dbg), .o_breakpoint_nop(nop), .o_runtime_count(run), .o_control(ctl),
    .o_link_error(lerr), .o_cmd_valid(cvalid), .o_cmd_word(cword), .i_cmd_ready(rdy));
  host_link #(.BIT(8)) i_host_link (.i_clk(clk), .i_line(line), .o_oe_n(host_oe_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic ok(input logic [7:0] c);
    if (!m_ctl[7]) return c inside {8'h00, 8'h02, 8'h04, 8'h05};
    return !(prot && c inside {8'h06, 8'h07, 8'h09, [8'h0a:8'h0c], [8'h10:8'h12]});
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic settle();
    bit q;
    i_host_link.quiet(q);
    if (!q) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input bit arg);
    if (!(c inside {8'h01, 8'h0f} || c >= 8'h13)) exp_q.push_back({1'b1, ok(c), c});
    if (arg) exp_q.push_back({1'b0, ok(c), a});
    i_host_link.rx.delete();
    i_host_link.send(c);
    if (arg) i_host_link.send(a);
    settle();
    if (ok(c) && c == 8'h00)
      check({i_host_link.rx[0], i_host_link.rx[1]}, DEBUG_REVISION);
    if (ok(c) && c == 8'h02)
      check(i_host_link.rx[0], {m_ctl[7], prot, 6'h00});
    if (ok(c) && c == 8'h05)
      check(i_host_link.rx[0], m_ctl);
  endtask
  task automatic wctl(input logic [7:0] v);
    xfer(8'h04, v, 1'b1);
    m_ctl = (prot && m_ctl[7]) ? (v | 8'h80) : v;
    check(ctl, m_ctl);
    check(dbg, m_ctl[7]);
  endtask
  task automatic brk_pulse();
    breakpoint_opcode = 1'b1;
    @(negedge clk);
    breakpoint_opcode = 1'b0;
    check(nop, !m_ctl[5]);
    if (m_ctl[5]) m_ctl[7] = 1'b1;
    check(dbg, m_ctl[7]);
  endtask

  // consumer stalls at random, held off entirely while filling the fifo
  always @(negedge clk) begin
    seed = xs(seed);
    rdy <= !hold && (seed[0] | seed[1]);
  end
  always @(posedge clk) begin
    if (lerr) n_err++;
    if (cvalid && rdy) check({6'h00, cword}, exp_q.size() ? {6'h00, exp_q.pop_front()} : 16'hffff);
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (UW + 8) @(negedge clk);
    i_host_link.send(8'h80);
    for (int i = 3; i >= 0; i--) i_host_link.send(UNLOCK_KEY[i*8+:8]);
    check(gpio, 1'b1);
    rpin = 1'b1;
    repeat (10) @(negedge clk);
    check(gpio, 1'b0);
    i_host_link.send(8'h80);
    settle();
    foreach (cl[i]) xfer(cl[i], 8'h00, 1'b0);
    brk_pulse();
    wctl(8'h80);
    foreach (cl[i]) xfer(cl[i], 8'h00, 1'b0);
    wctl(8'h20);
    r = run;
    repeat (10) @(negedge clk);
    check(run, r + 16'h000a);
    brk_pulse();
    r = run;
    repeat (10) @(negedge clk);
    check(run, r);
    prot = 1'b1;
    foreach (cl[i]) xfer(cl[i], 8'h00, 1'b0);
    hold = 1'b1;
    repeat (4) xfer(8'h0e, 8'h00, 1'b0);
    check(cvalid, 1'b1);
    hold = 1'b0;
    wctl(8'h20);
    i_host_link.hold_low(12);
    settle();
    check(16'(n_err), 16'h0001);
    i_host_link.send(8'h80);
    settle();
    xfer(8'h02, 8'h00, 1'b0);
    check(exp_q.size(), 16'h0000);
    summarize();
  end
endmodule
